/* File: apms_consts.vh */
`ifndef APMS_CONSTS_VH
`define APMS_CONSTS_VH
// Power mode encodings {power_bit_high, power_bit_low}.
`define APMS_PM_NORMAL 2'h3
`define APMS_PM_FULL_SHDN 2'h2
`define APMS_PM_AUTO_SHDN 2'h1
`define APMS_PM_AUTO_STBY 2'h0
// Control word layout within the 12 captured bits (bit 11 is the update flag).
`define APMS_CTL_WRITE 11
`define APMS_CTL_CYCLE 10
`define APMS_CTL_ADDR_MSB 9
`define APMS_CTL_ADDR_LSB 6
`define APMS_CTL_PM_HI 5
`define APMS_CTL_PM_LO 4
`define APMS_CTL_LIST 3
`define APMS_CTL_KEEPER 2
// Control register and channel list reset values.
`define APMS_CTL_RESET 12'hFF0
`define APMS_CHLIST_RESET 16'h0000
// Transfer edge counts.
`define APMS_CTL_BITS 5'h0C
`define APMS_TRACK_EDGE 5'h0E
`define APMS_WORD_BITS 5'h10
// Wake-up time in nanoseconds and clock period.
`define APMS_WAKE_NS 1000
`define APMS_CLK_NS 25
`define APMS_WAKE_CYC ((`APMS_WAKE_NS + `APMS_CLK_NS - 1) / `APMS_CLK_NS)
`endif

/* File: apms_sync.v */
`timescale 1ns/1ps
`include "apms_consts.vh"
// Two-flop synchroniser; the first stage feeds only the second.
module apms_sync (
    input wire ref_clk,
    input wire arst_n,
    input wire clk_en,
    input wire din,
    output reg dout
);
    reg meta_q;

    // Reset to high matches the idle level of chip select and clock.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b1;
            dout <= 1'b1;
        end else if (clk_en) begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

/* File: apms_seq.v */
`timescale 1ns/1ps
`include "apms_consts.vh"
//Contract
// R1: Power bits select mode: 11 normal, 10 full shutdown, 01 auto shutdown, 00 standby.
// R2: Chip select falling edge holds the track-and-hold and starts a conversion.
// R3: First 12 serial input bits load control register only if update flag set.
// R4: After a write with auto-cycle 0 and list 1, load 16 bits into list.
// R5: Stay powered after conversion only if that write kept both power bits 1.
// R6: A conversion and readout takes sixteen serial clocks; host supplies all.
// R7: In normal mode tracking resumes on the 14th serial clock falling edge; in list frames the code waits for chip select rise.
// R8: Host may idle chip select high or low between conversions.
// R9: Host waits the quiet interval before the next chip select fall.
// R10: Full shutdown powers down, keeps control, stays until power bits change.
// R11: Wake from full shutdown starts at chip select rise; track on edge 14.
// R12: Host waits power-up time after commanding a wake from full shutdown.
// R13: Auto shutdown powers down at each conversion end, holding the sample.
// R14: From auto shutdown wake on chip select fall, needing 1 us.
// R15: In auto modes host precedes valid conversions with a dummy transfer.
// R16: Auto standby partly powers down, keeps bias, wakes on chip select fall.
// R17: After power-up the mode may be any; control contents are undefined.
// R18: Host runs two held-high transfers then writes configuration in the third.
// R19: Host writes the channel list no earlier than the fourth conversion cycle.
// R20: Host may skip the second dummy when targeting normal or full shutdown.
// R21: Output word holds four channel tag bits then the 12-bit result.
// R22: Update flag is the incoming MSB; control captured on first 12 falls.
// R23: With keeper bit 0 the output is released on the 16th falling edge.
// R24: A new power mode is pending until the current conversion ends.
module apms_seq (
    input wire ref_clk,
    input wire arst_n,
    input wire clk_en,
    input wire cs_n,
    input wire sclk,
    input wire sdi,
    input wire [11:0] result,
    output reg sdo_o,
    output reg sdo_oe,
    output reg track_q,
    output reg [1:0] mode_q,
    output reg bias_on_q,
    output reg core_on_q,
    output reg wake_ready_q,
    output reg [11:0] ctl_q,
    output reg [15:0] chlist_q,
    output reg [3:0] chan_q,
    output reg conv_done_q
);
    // Synchronised pins and the history that turns them into edges.
    wire cs_s;
    wire sclk_s;
    reg cs_d1_q;
    reg sclk_d1_q;
    reg [4:0] edge_q;
    reg [15:0] shift_q;
    reg [15:0] out_q;
    reg list_arm_q;
    reg list_now_q;
    reg [1:0] pend_q;
    reg [5:0] wake_q;
    reg active_q;
    wire cs_fall = cs_d1_q & ~cs_s;
    wire cs_rise = ~cs_d1_q & cs_s;
    wire sclk_fall = sclk_d1_q & ~sclk_s & active_q;
    wire sdi_s;
    wire [15:0] shift_d = {shift_q[14:0], sdi_s};

    // All three pins share the same two-flop delay, so data and clock stay aligned.
    apms_sync u_cs (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .din(cs_n),
        .dout(cs_s));
    apms_sync u_sclk (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .din(sclk),
        .dout(sclk_s));
    apms_sync u_sdi (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .din(sdi),
        .dout(sdi_s));

    // Edge history registers for the synchronised pins.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_d1_q <= 1'b1;
            sclk_d1_q <= 1'b1;
        end else if (clk_en) begin
            cs_d1_q <= cs_s;
            sclk_d1_q <= sclk_s;
        end
    end

    // Transfer framing: edges are counted only while chip select is low.
    // The count stops at 16, so surplus clocks in a long frame change nothing.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            active_q <= 1'b0;
            edge_q <= 5'h00;
            shift_q <= 16'h0000;
        end else if (clk_en) begin
            if (cs_fall) begin
                active_q <= 1'b1; // [R2]
                edge_q <= 5'h00;
            end else if (cs_rise) begin
                active_q <= 1'b0;
            end else if (sclk_fall && edge_q != `APMS_WORD_BITS) begin
                edge_q <= edge_q + 5'h01;
                shift_q <= shift_d;
            end
        end
    end

    // Control and channel-list capture. A write during a list transfer goes to the
    // list only, so the control word is not disturbed by list data.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_q <= `APMS_CTL_RESET; // [R17]
            chlist_q <= `APMS_CHLIST_RESET;
            list_arm_q <= 1'b0;
            list_now_q <= 1'b0;
        end else if (clk_en) begin
            if (cs_fall) begin
                list_now_q <= list_arm_q;
                list_arm_q <= 1'b0;
            end else if (sclk_fall && !list_now_q && edge_q == `APMS_CTL_BITS - 5'h01) begin
                if (shift_d[11]) begin // [R22]
                    ctl_q <= shift_d[11:0]; // [R3]
                    list_arm_q <= ~shift_d[`APMS_CTL_CYCLE] & shift_d[`APMS_CTL_LIST]; // [R4]
                end
            end else if (sclk_fall && list_now_q && edge_q == `APMS_WORD_BITS - 5'h01) begin
                chlist_q <= shift_d; // [R4]
            end
        end
    end

    // Power mode: new bits wait as pending until the conversion ends at chip select rise.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= `APMS_PM_NORMAL;
            pend_q <= `APMS_PM_NORMAL;
            conv_done_q <= 1'b0;
        end else if (clk_en) begin
            conv_done_q <= cs_rise & (edge_q == `APMS_WORD_BITS); // [R6]
            pend_q <= {ctl_q[`APMS_CTL_PM_HI], ctl_q[`APMS_CTL_PM_LO]};
            if (cs_rise) begin
                mode_q <= pend_q; // [R24] [R1] [R5] [R13] [R10]
            end
        end
    end

    // Power state. Auto modes sleep at conversion end and wake on chip select fall;
    // full shutdown only leaves when the mode changes, starting at chip select rise.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            core_on_q <= 1'b1;
            bias_on_q <= 1'b1;
            wake_q <= 6'h00;
            wake_ready_q <= 1'b1;
        end else if (clk_en) begin
            if (cs_rise) begin
                core_on_q <= (pend_q == `APMS_PM_NORMAL); // [R5] [R11] [R13]
                bias_on_q <= (pend_q != `APMS_PM_FULL_SHDN)
                    && (pend_q != `APMS_PM_AUTO_SHDN); // [R16]
                if (pend_q == `APMS_PM_NORMAL && !core_on_q) begin
                    wake_q <= 6'h00;
                    wake_ready_q <= 1'b0;
                end
            end else if (cs_fall && mode_q != `APMS_PM_NORMAL
                    && mode_q != `APMS_PM_FULL_SHDN) begin
                core_on_q <= 1'b1; // [R14] [R16]
                bias_on_q <= 1'b1;
                wake_q <= 6'h00;
                wake_ready_q <= 1'b0;
            end else if (!wake_ready_q) begin
                if (wake_q == `APMS_WAKE_CYC - 1) begin
                    wake_ready_q <= 1'b1; // [R14]
                end else begin
                    wake_q <= wake_q + 6'h01;
                end
            end
        end
    end

    // Track-and-hold: hold on chip select fall, track on the 14th falling edge,
    // except during list writes, where it waits for chip select rise.
    // A conversion that ends in a low-power mode leaves the sample held, because
    // nothing is powered to track with until the next wake.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            track_q <= 1'b1;
        end else if (clk_en) begin
            if (cs_fall) begin
                track_q <= 1'b0; // [R2]
            end else if (sclk_fall && edge_q == `APMS_TRACK_EDGE - 5'h01 && !list_now_q
                    && (core_on_q || pend_q == `APMS_PM_NORMAL)) begin
                track_q <= 1'b1; // [R7] [R11]
            end else if (cs_rise && pend_q != `APMS_PM_NORMAL) begin
                track_q <= 1'b0; // [R13] [R16] [R10]
            end else if (cs_rise && list_now_q) begin
                track_q <= 1'b1;
            end
        end
    end

    // Serial output: tag then result, first bit on chip select fall.
    // The word is taken whole at the fall, so a result changing mid-frame cannot tear it.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_q <= 16'h0000;
            sdo_o <= 1'b0;
            sdo_oe <= 1'b0;
            chan_q <= 4'h0;
        end else if (clk_en) begin
            if (cs_fall) begin
                chan_q <= ctl_q[`APMS_CTL_ADDR_MSB:`APMS_CTL_ADDR_LSB];
                out_q <= {ctl_q[`APMS_CTL_ADDR_MSB:`APMS_CTL_ADDR_LSB], result}; // [R21]
                sdo_o <= ctl_q[`APMS_CTL_ADDR_MSB];
                sdo_oe <= 1'b1;
            end else if (sclk_fall) begin
                out_q <= {out_q[14:0], 1'b0};
                sdo_o <= out_q[14];
                if (edge_q == `APMS_WORD_BITS - 5'h01) begin
                    sdo_oe <= ctl_q[`APMS_CTL_KEEPER]; // [R23]
                end
            end
        end
    end
endmodule

/* File: apms_seq_props.sv */
`timescale 1ns/1ps
`include "apms_consts.vh"
// Pin edges reach the core a few clocks late, so cause and effect are given slack.
module apms_props (
    input wire ref_clk,
    input wire arst_n,
    input wire clk_en,
    input wire cs_n,
    input wire sdo_oe,
    input wire track_q,
    input wire [1:0] mode_q,
    input wire bias_on_q,
    input wire core_on_q,
    input wire [11:0] ctl_q,
    input wire conv_done_q
);
    default clocking @(posedge ref_clk); endclocking
    // A frozen core ignores the pins, so nothing is judged while the enable is low.
    default disable iff (!arst_n || !clk_en);
    hold_on_fall_a: assert property (
        $fell(cs_n) |-> ##[1:6] (!track_q && sdo_oe)) else $error("no hold at select");
    done_single_a: assert property (
        conv_done_q |=> !conv_done_q) else $error("done too long");
    done_cs_high_a: assert property (
        conv_done_q |-> cs_n) else $error("done while selected");
    mode_at_end_a: assert property (
        $changed(mode_q) |-> conv_done_q) else $error("mode moved mid frame");
    mode_follows_a: assert property (
        conv_done_q |-> mode_q == ctl_q[5:4]) else $error("mode not from control");
    ctl_idle_a: assert property (
        cs_n && $past(cs_n, 4) |-> $stable(ctl_q)) else $error("control moved idle");
    normal_on_a: assert property (
        mode_q == `APMS_PM_NORMAL && $stable(mode_q) |-> core_on_q) else $error("core off");
    shdn_off_a: assert property (
        mode_q == `APMS_PM_FULL_SHDN && $stable(mode_q) |-> !core_on_q && !bias_on_q)
        else $error("shutdown powered");
    stby_bias_a: assert property (
        mode_q == `APMS_PM_AUTO_STBY |-> bias_on_q) else $error("bias off in standby");
    sleep_hold_a: assert property (
        conv_done_q && mode_q != `APMS_PM_NORMAL |-> !track_q) else $error("sample not held");
    cover property (conv_done_q && mode_q == `APMS_PM_AUTO_SHDN);
    cover property (conv_done_q && mode_q == `APMS_PM_FULL_SHDN);
    cover property (conv_done_q && mode_q == `APMS_PM_AUTO_STBY);
endmodule
bind apms_seq apms_props u_props (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .cs_n(cs_n), .sdo_oe(sdo_oe), .track_q(track_q), .mode_q(mode_q),
    .bias_on_q(bias_on_q), .core_on_q(core_on_q), .ctl_q(ctl_q), .conv_done_q(conv_done_q));

/* File: apms_host.sv */
`timescale 1ns/1ps
// Host serial master; its clock idles high and stands still between frames.
module apms_host (
    input wire ref_clk,
    input wire sdo_o,
    output reg cs_n,
    output reg sclk,
    output reg sdi
);
    // One frame of sixteen clocks, MSB first; the reply is taken just before each fall.
    task automatic xfer(input [15:0] w, output [15:0] r);
        integer i;
        begin
            @(negedge ref_clk) cs_n = 1'b0;
            repeat (8) @(negedge ref_clk);
            for (i = 15; i >= 0; i = i - 1) begin
                sdi = w[i];
                sclk = 1'b1;
                repeat (4) @(negedge ref_clk);
                r[i] = sdo_o;
                sclk = 1'b0;
                repeat (4) @(negedge ref_clk);
            end
            sclk = 1'b1;
            sdi = ~w[0];
            repeat (4) @(negedge ref_clk);
            cs_n = 1'b1;
            repeat (12) @(negedge ref_clk);
        end
    endtask
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        sdi = 1'b0;
    end
endmodule

/* File: apms_seq_tb.sv */
`timescale 1ns/1ps
// Drives the sequencer through the host model and checks registers between frames.
module apms_seq_tb;
    reg ref_clk = 1'b0;
    reg arst_n = 1'b0;
    reg clk_en = 1'b1;
    reg [11:0] result = 12'h9B7;
    reg [15:0] rd;
    integer fails = 0;
    integer samples_checked = 0;
    integer k;
    wire cs_n, sclk, sdi, sdo_o, sdo_oe, track_q, bias_on_q, core_on_q, wake_ready_q;
    wire conv_done_q;
    wire [1:0] mode_q;
    wire [11:0] ctl_q;
    wire [15:0] chlist_q;
    wire [3:0] chan_q;
    always #12.5 ref_clk = ~ref_clk;
    apms_seq u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .cs_n(cs_n),
        .sclk(sclk), .sdi(sdi), .result(result), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .track_q(track_q), .mode_q(mode_q), .bias_on_q(bias_on_q), .core_on_q(core_on_q),
        .wake_ready_q(wake_ready_q), .ctl_q(ctl_q), .chlist_q(chlist_q), .chan_q(chan_q),
        .conv_done_q(conv_done_q));
    apms_host u_host (.ref_clk(ref_clk), .sdo_o(sdo_o), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));
    // Counts one comparison and reports a mismatch at once.
    task check(input [63:0] nm, input [15:0] exp, input [15:0] got);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("ERROR %0s expected %h got %h", nm, exp, got);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("fails=%0d samples_checked=%0d", fails, samples_checked);
            if (fails == 0 && samples_checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // One held-high frame with keeper set; a normal target lets the second one go.
    task t_powerup;
        begin
            u_host.xfer(16'hFFFF, rd);
            check("ctl", 16'h0FFF, {4'h0, ctl_q});
            check("oe", 16'h0001, {15'h0, sdo_oe});
        end
    endtask
    // Every power code in turn, ending in normal so the wake path is crossed too.
    // An auto mode gets one dummy frame with the update flag clear before it is left,
    // then a wake from full shutdown is timed against the 1 us power-up.
    task t_modes;
        reg [1:0] pm;
        begin
            for (k = 0; k < 5; k = k + 1) begin
                pm = 2'h3 - k[1:0];
                u_host.xfer({4'h9, 2'h1, pm, 8'h00}, rd);
                if (!pm[1]) begin
                    u_host.xfer(16'h0000, rd);
                end
                check("ctl", {4'h0, 4'h9, 2'h1, pm, 4'h0}, {4'h0, ctl_q});
                check("mode", {14'h0, pm}, {14'h0, mode_q});
                check("core", {15'h0, pm == 2'h3}, {15'h0, core_on_q});
                check("bias", {15'h0, pm == 2'h3 || pm == 2'h0}, {15'h0, bias_on_q});
                check("track", {15'h0, pm == 2'h3}, {15'h0, track_q});
                check("wake", 16'h0001, {15'h0, wake_ready_q});
            end
            u_host.xfer({4'h9, 2'h1, 2'h2, 8'h00}, rd);
            u_host.xfer({4'h9, 2'h1, 2'h3, 8'h00}, rd);
            check("core", 16'h0001, {15'h0, core_on_q});
            check("track", 16'h0001, {15'h0, track_q});
            check("wake", 16'h0000, {15'h0, wake_ready_q});
            repeat (48) @(negedge ref_clk);
            check("wake", 16'h0001, {15'h0, wake_ready_q});
        end
    endtask
    // A frame with the update flag clear reads the result and leaves control alone.
    task t_read;
        begin
            u_host.xfer(16'h0000, rd);
            check("word", {4'h5, 12'h9B7}, rd);
            check("chan", 16'h0005, {12'h0, chan_q});
            check("ctl", 16'h0970, {4'h0, ctl_q});
            check("oe", 16'h0000, {15'h0, sdo_oe});
            check("track", 16'h0001, {15'h0, track_q});
        end
    endtask
    // Arms the list, then the next full word lands in it untouched.
    task t_list;
        begin
            u_host.xfer(16'h9780, rd);
            u_host.xfer(16'hA5C3, rd);
            check("list", 16'hA5C3, chlist_q);
            check("ctl", 16'h0978, {4'h0, ctl_q});
        end
    endtask
    // With the clock enable low a whole writing frame passes unseen and nothing moves.
    task t_freeze;
        begin
            @(negedge ref_clk) clk_en = 1'b0;
            u_host.xfer({4'h9, 2'h1, 2'h2, 8'h00}, rd);
            @(negedge ref_clk) clk_en = 1'b1;
            repeat (8) @(negedge ref_clk);
            check("ctl", 16'h0978, {4'h0, ctl_q});
            check("mode", 16'h0003, {14'h0, mode_q});
        end
    endtask
    initial begin
        repeat (5) @(negedge ref_clk);
        arst_n = 1'b1;
        t_powerup;
        t_modes;
        t_read;
        t_list;
        t_freeze;
        report_and_stop;
    end
    // Fourteen frames need about 55 us, so 150 us means a hang.
    initial begin
        #150000;
        fails = fails + 1;
        report_and_stop;
    end
endmodule
